// file: src/tscfg_regs.sv
/*
 Configuration register bank of the touch controller on an AHB-Lite slave,
 with the timeout monitor of the serial management pins and per-channel
 delta paths. Assumes one 40 MHz clock, pins asynchronous to it, and a
 sensing core that drives raw deltas, noise flags and status events.
*/
`timescale 1ns/10ps
`include "tscfg_params.svh"
module tscfg_regs #(
	parameter int NCH         = 6,
	parameter int LOW_TMO_CYC = `TSCFG_LOW_TMO_CYC
) (
	input  wire logic                   CLOCK,
	input  wire logic                   ARST_N,
	input  wire logic                   HSEL,
	input  wire logic [31:0]            HADDR,
	input  wire tscfg_pkg::tscfg_htrans_t HTRANS,
	input  wire logic                   HWRITE,
	input  wire logic [2:0]             HSIZE,
	input  wire logic [31:0]            HWDATA,
	input  wire logic                   HREADY,
	output logic      [31:0]            HRDATA,
	output logic                        HREADYOUT,
	output logic                        HRESP,
	input  wire logic                   SCL_PIN,
	input  wire logic                   SDA_PIN,
	input  wire logic                   CYCLE_STROBE,
	input  wire logic [NCH*16-1:0]      RAW_DELTA,
	input  wire logic [NCH-1:0]         LF_NOISE,
	input  wire logic [NCH-1:0]         RF_NOISE,
	input  wire logic [7:0]             TOUCH_THR,
	input  wire logic [7:0]             NOISE_THR,
	input  wire logic                   BASELINE_RANGE_FAULT_FLAG,
	input  wire logic                   CALIB_FAILURE_FLAG,
	input  wire logic [NCH-1:0]         PER_INPUT_BASELINE_FAULT,
	input  wire logic                   PRESS_EVENT,
	input  wire logic                   RELEASE_EVENT,
	input  wire logic                   REPEAT_EVENT,
	input  wire logic                   LAST_CONV_DONE,
	input  wire logic                   HOLD_EXPIRED,
	input  wire logic [15:0]            BASE_COUNT,
	output logic      [NCH*8-1:0]       DELTA_OUT,
	output logic      [NCH-1:0]         NOISE_STATUS,
	output logic      [NCH-1:0]         RECAL_SAMPLE_OK,
	output logic      [NCH-1:0]         RECAL_RETRY,
	output logic                        LONG_HOLD_RECAL,
	output logic                        LOW_POWER,
	output logic                        IRQ_REQ,
	output logic      [15:0]            BASE_COUNT_VIEW,
	output logic                        BUS_RESET
);
	import tscfg_pkg::*;

	// Register state
	tscfg_byte_t sens_q;  // Gain and base shift
	tscfg_byte_t cfg1_q;  // Timeout and noise gates
	tscfg_byte_t cfg2_q;  // Calibration, power, interrupt gating
	// Shadow copies applied at the sensing cycle boundary
	tscfg_byte_t sens_a_q;
	tscfg_byte_t cfg1_a_q;
	tscfg_byte_t cfg2_a_q;

	// Bus data phase state
	logic        dp_wr_q;   // Write pending in data phase
	logic [7:0]  dp_adr_q;  // Latched address index
	tscfg_bus_st_t bus_st_q;

	// Decode of the address phase
	wire         ap_valid = HSEL & HREADY & (HTRANS == TSCFG_HTR_NONSEQ);
	wire         ap_rd    = ap_valid & ~HWRITE;
	// Only aligned word addresses inside the first 1 KiB map; anything else
	// folds to index 0, which holds no register, so no alias can hit a register
	wire         ap_in    = (HADDR[31:10] == 22'h00_0000) & (HADDR[1:0] == 2'h0);
	wire [7:0]   ap_adr   = ap_in ? HADDR[9:2] : 8'h00;
	wire         hit_sens = (dp_adr_q == `TSCFG_IDX_SENS);
	wire         hit_cfg1 = (dp_adr_q == `TSCFG_IDX_CFG1);
	wire         hit_cfg2 = (dp_adr_q == `TSCFG_IDX_CFG2);
	wire [7:0]   wbyte    = HWDATA[7:0];
	// Read mux; unmapped reads zero
	wire         r_sens   = (ap_adr == `TSCFG_IDX_SENS);
	wire         r_cfg1   = (ap_adr == `TSCFG_IDX_CFG1);
	wire         r_cfg2   = (ap_adr == `TSCFG_IDX_CFG2);
	wire [7:0]   rd_mask  = r_sens ? `TSCFG_MASK_SENS :
		r_cfg1 ? `TSCFG_MASK_CFG1 :
		r_cfg2 ? `TSCFG_MASK_CFG2 : 8'h00;
	wire [7:0]   rd_cur   = r_sens ? sens_q : r_cfg1 ? cfg1_q : r_cfg2 ? cfg2_q : 8'h00;
	// A write still in its data phase is passed on, so a read issued right
	// behind it returns the new value, not the one about to be replaced
	wire         rd_fwd   = dp_wr_q & (bus_st_q == TSCFG_BUS_ACTIVE) & (dp_adr_q == ap_adr);
	// Masking last keeps unassigned bits at zero on both paths
	wire [7:0]   rd_byte  = (rd_fwd ? wbyte : rd_cur) & rd_mask;

	// Address phase latch; zero-wait slave
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			dp_wr_q  <= 1'b0;
			dp_adr_q <= 8'h00;
			bus_st_q <= TSCFG_BUS_IDLE;
		end
		else if (HREADY)
		begin
			dp_wr_q  <= ap_valid & HWRITE;
			dp_adr_q <= ap_adr;
			bus_st_q <= ap_valid ? TSCFG_BUS_ACTIVE : TSCFG_BUS_IDLE;
		end
	end

	// Read data captured at address phase, shown in data phase
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
		else
		begin
			HREADYOUT <= 1'b1; // Never stalls
			HRESP     <= 1'b0; // Always OKAY
			if (ap_rd)
				HRDATA <= {24'h00_0000, rd_byte};
		end
	end

	// Register writes; unassigned bits masked off
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sens_q <= `TSCFG_RST_SENS;
			cfg1_q <= `TSCFG_RST_CFG1;
			cfg2_q <= `TSCFG_RST_CFG2;
		end
		else if (dp_wr_q)
		begin
			if (hit_sens)
				sens_q <= wbyte & `TSCFG_MASK_SENS;
			if (hit_cfg1)
				cfg1_q <= wbyte & `TSCFG_MASK_CFG1;
			if (hit_cfg2)
				cfg2_q <= wbyte & `TSCFG_MASK_CFG2;
		end
	end

	// Settings take effect at the next sensing cycle
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sens_a_q <= `TSCFG_RST_SENS;
			cfg1_a_q <= `TSCFG_RST_CFG1;
			cfg2_a_q <= `TSCFG_RST_CFG2;
		end
		else if (CYCLE_STROBE)
		begin
			sens_a_q <= sens_q;
			cfg1_a_q <= cfg1_q;
			cfg2_a_q <= cfg2_q;
		end
	end

	// Decoded active fields
	wire [2:0] gain_code = sens_a_q[`TSCFG_SENS_GAIN_LSB +: 3];
	wire [3:0] shift_code = sens_a_q[`TSCFG_SENS_SHIFT_LSB +: 4];
	wire       tmo_en    = cfg1_a_q[`TSCFG_C1_TIMEOUT];
	wire       dig_off   = cfg1_a_q[`TSCFG_C1_DIGNOISE];
	wire       lf_off    = cfg1_a_q[`TSCFG_C1_LFNOISE];
	wire       hold_en   = cfg1_a_q[`TSCFG_C1_LONGHOLD];
	wire       retry_en  = cfg2_a_q[`TSCFG_C2_RETRY];
	wire       pwr_blk   = cfg2_a_q[`TSCFG_C2_PWRBLK];
	wire       bc_ie     = cfg2_a_q[`TSCFG_C2_BCINT];
	wire       rf_only   = cfg2_a_q[`TSCFG_C2_RFONLY];
	wire       rf_off    = cfg2_a_q[`TSCFG_C2_RFNOISE];
	wire       cal_ie    = cfg2_a_q[`TSCFG_C2_CALINT];
	wire       rel_sup   = cfg2_a_q[`TSCFG_C2_RELSUP];

	// Synchronisers for the management pins
	logic [1:0] scl_s_q; // Bit 0 read only by bit 1
	logic [1:0] sda_s_q;
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			scl_s_q <= 2'b11;
			sda_s_q <= 2'b11;
		end
		else
		begin
			scl_s_q <= {scl_s_q[0], SCL_PIN};
			sda_s_q <= {sda_s_q[0], SDA_PIN};
		end
	end
	wire scl = scl_s_q[1];
	wire sda = sda_s_q[1];

	// Low and idle timers; counters saturate one past their limit
	logic [31:0] low_cnt_q;
	logic [31:0] idle_cnt_q;
	wire         low_over  = (low_cnt_q > LOW_TMO_CYC[31:0]);
	wire         idle_over = (idle_cnt_q > 32'(`TSCFG_IDLE_TMO_CYC));
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			low_cnt_q  <= 32'h0000_0000;
			idle_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			// Counters clear to zero while the feature is off
			if (!tmo_en || scl || BUS_RESET)
				low_cnt_q <= 32'h0000_0000;
			else if (!low_over)
				low_cnt_q <= low_cnt_q + 32'h0000_0001;
			if (!tmo_en || !scl || !sda || BUS_RESET)
				idle_cnt_q <= 32'h0000_0000;
			else if (!idle_over)
				idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
		end
	end

	// One-cycle interface reset pulse
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			BUS_RESET <= 1'b0;
		else
			BUS_RESET <= ~BUS_RESET & tmo_en & (low_over | idle_over);
	end

	// Per-channel delta paths
	logic [NCH*8-1:0] delta_w;
	logic [NCH-1:0]   noise_w;
	logic [NCH-1:0]   recal_w;
	for (genvar i = 0; i < NCH; i++)
	begin : g_chan
		tscfg_chan u_chan (
			.clk          (CLOCK),
			.arst_n       (ARST_N),
			.cyc_en       (CYCLE_STROBE),
			.raw_delta    (RAW_DELTA[i*16 +: 16]),
			.gain_code    (gain_code),
			.lf_noise     (LF_NOISE[i]),
			.rf_noise     (RF_NOISE[i]),
			.lf_off       (lf_off),
			.rf_off       (rf_off),
			.rf_only      (rf_only),
			.dig_gate_off (dig_off),
			.touch_thr    (TOUCH_THR),
			.noise_thr    (NOISE_THR),
			.delta_q      (delta_w[i*8 +: 8]),
			.noise_q      (noise_w[i]),
			.recal_q      (recal_w[i])
		);
	end

	// Base count view: presentation only, shift codes above 7 clamp
	wire [2:0]  sh3  = shift_code[3] ? 3'd7 : shift_code[2:0];
	wire [15:0] bview = BASE_COUNT >> sh3;

	// Baseline and calibration interrupts gated by enables; press, repeat ungated
	logic bc_d_q;  // Previous baseline fault
	logic cal_d_q; // Previous calibration failure
	wire  bc_rise  = BASELINE_RANGE_FAULT_FLAG & ~bc_d_q;
	wire  cal_rise = CALIB_FAILURE_FLAG & ~cal_d_q;
	wire  irq_next = (bc_rise & bc_ie)
		| (cal_rise & cal_ie)
		| PRESS_EVENT | REPEAT_EVENT
		| (RELEASE_EVENT & ~rel_sup);

	// Registered outputs
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			DELTA_OUT       <= '0;
			NOISE_STATUS    <= '0;
			RECAL_SAMPLE_OK <= '0;
			RECAL_RETRY     <= '0;
			LONG_HOLD_RECAL <= 1'b0;
			LOW_POWER       <= 1'b0;
			IRQ_REQ         <= 1'b0;
			BASE_COUNT_VIEW <= 16'h0000;
			bc_d_q          <= 1'b0;
			cal_d_q         <= 1'b0;
		end
		else
		begin
			DELTA_OUT       <= delta_w;
			NOISE_STATUS    <= noise_w;
			RECAL_SAMPLE_OK <= recal_w;
			// Without retry the out-of-range count stays in use
			RECAL_RETRY     <= retry_en ? PER_INPUT_BASELINE_FAULT : '0;
			LONG_HOLD_RECAL <= hold_en & HOLD_EXPIRED;
			// Low power from last conversion to cycle end; a conversion that
			// finishes on the boundary itself still enters low power
			if (LAST_CONV_DONE && !pwr_blk)
				LOW_POWER <= 1'b1;
			else if (CYCLE_STROBE)
				LOW_POWER <= 1'b0;
			IRQ_REQ         <= irq_next;
			BASE_COUNT_VIEW <= bview;
			bc_d_q          <= BASELINE_RANGE_FAULT_FLAG;
			cal_d_q         <= CALIB_FAILURE_FLAG;
		end
	end
endmodule : tscfg_regs

// file: inc/tscfg_params.svh
/*
 Constants of the touch sensing configuration register bank: word indices,
 field positions, reset values and timing figures. Assumes a 40 MHz clock.
*/
// Notes on behaviour
// - Sensitivity code 000b is 128x, halving to 1x.
// - Delta scaled by multiplier before threshold; default 32x.
// - Base shift 0..7 presents base counts divided by 1..128.
// - Base shift alters only presentation, never detection.
// - Timeout bit clear: serial interface never times out.
// - Timeout set: clock low over 30ms resets interface.
// - Timeout set: both lines high 200us resets interface.
// - Noise gate on: noisy sub-touch samples skip recalibration.
// - Noise gate off: all sub-touch deltas feed recalibration.
// - Low-frequency noise zeroes delta unless filter off.
// - Long hold recalibrates only when enabled.
// - Retry bit repeats calibration on out-of-range inputs.
// - Power-save between conversions unless block bit set.
// - Baseline fault interrupts only when enabled.
// - Radio-only report hides low-frequency noise from status.
// - Radio noise zeroes delta unless filter off.
// - Calibration failure interrupts only when enabled.
// - Suppress bit drops release interrupts only.
// - Scaled delta saturates at 7Fh and 80h.
// - Noise flag holds delta at 00h unless its filter is off.
`ifndef TSCFG_PARAMS_SVH
`define TSCFG_PARAMS_SVH

// Register word indices; the bus byte address is four times the index
`define TSCFG_IDX_SENS       8'h1F
`define TSCFG_IDX_CFG1       8'h20
`define TSCFG_IDX_CFG2       8'h44
// Reset values
`define TSCFG_RST_SENS       8'h2F
`define TSCFG_RST_CFG1       8'h20
`define TSCFG_RST_CFG2       8'h40
// Writable bit masks
`define TSCFG_MASK_SENS      8'h7F
`define TSCFG_MASK_CFG1      8'hB8
`define TSCFG_MASK_CFG2      8'h7F
// Field positions, sensitivity register
`define TSCFG_SENS_GAIN_LSB  4
`define TSCFG_SENS_SHIFT_LSB 0
// Field positions, first configuration register
`define TSCFG_C1_TIMEOUT     7
`define TSCFG_C1_DIGNOISE    5
`define TSCFG_C1_LFNOISE     4
`define TSCFG_C1_LONGHOLD    3
// Field positions, second configuration register
`define TSCFG_C2_RETRY       6
`define TSCFG_C2_PWRBLK      5
`define TSCFG_C2_BCINT       4
`define TSCFG_C2_RFONLY      3
`define TSCFG_C2_RFNOISE     2
`define TSCFG_C2_CALINT      1
`define TSCFG_C2_RELSUP      0
// Timing
`define TSCFG_CLK_HZ         40000000
`define TSCFG_LOW_TMO_US     30000
`define TSCFG_IDLE_TMO_US    200
`define TSCFG_LOW_TMO_CYC    ((`TSCFG_LOW_TMO_US * (`TSCFG_CLK_HZ / 1000000)) / 1)
`define TSCFG_IDLE_TMO_CYC   ((`TSCFG_IDLE_TMO_US * (`TSCFG_CLK_HZ / 1000000)) / 1)

`endif

// file: inc/tscfg_pkg.sv
/*
 Types of the touch sensing configuration bank.
 Assumes the params header is included by design files.
*/
package tscfg_pkg;
	typedef enum logic [1:0] {TSCFG_HTR_IDLE, TSCFG_HTR_BUSY, TSCFG_HTR_NONSEQ, TSCFG_HTR_SEQ}
		tscfg_htrans_t;
	typedef logic [7:0] tscfg_byte_t;
	typedef enum {TSCFG_BUS_IDLE, TSCFG_BUS_ACTIVE} tscfg_bus_st_t;
endpackage : tscfg_pkg

// file: src/tscfg_chan.sv
/*
 One sensing channel's delta path: gain, noise blanking, saturation and
 recalibration eligibility. Assumes inputs already on the core clock.
*/
`timescale 1ns/10ps
`include "tscfg_params.svh"
module tscfg_chan (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        cyc_en,    // Sensing cycle strobe
	input  wire logic [15:0] raw_delta, // Signed raw delta
	input  wire logic [2:0]  gain_code,
	input  wire logic        lf_noise,
	input  wire logic        rf_noise,
	input  wire logic        lf_off,
	input  wire logic        rf_off,
	input  wire logic        rf_only,
	input  wire logic        dig_gate_off,
	input  wire logic [7:0]  touch_thr,
	input  wire logic [7:0]  noise_thr,
	output logic      [7:0]  delta_q,   // Saturated scaled delta
	output logic             noise_q,   // Reported noise status
	output logic             recal_q    // Sample usable for recalibration
);
	import tscfg_pkg::*;
	logic signed [23:0] scaled;     // Raw delta times gain
	logic        [7:0]  sat;        // Saturated byte
	logic               blank;      // Noise forces zero
	logic        [7:0]  d_eff;      // Delta after blanking
	logic               over_noise; // Above noise threshold
	logic               over_touch; // At or above touch threshold

	// 128x at code 0, halving per step
	assign scaled = $signed({{8{raw_delta[15]}}, raw_delta}) <<< (3'd7 - gain_code);
	assign sat = (scaled > 24'sd127) ? 8'h7F :
		(scaled < -24'sd128) ? 8'h80 : scaled[7:0];
	// Blocking is independent of what status shows
	assign blank = (lf_noise & ~lf_off) | (rf_noise & ~rf_off);
	assign d_eff = blank ? 8'h00 : sat;
	assign over_touch = ~d_eff[7] && (d_eff >= touch_thr);
	assign over_noise = ~d_eff[7] && (d_eff > noise_thr);

	// Update once per sensing cycle so settings land next cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			delta_q <= 8'h00;
			noise_q <= 1'b0;
			recal_q <= 1'b0;
		end
		else if (cyc_en)
		begin
			delta_q <= d_eff;
			noise_q <= rf_noise | (lf_noise & ~rf_only);
			recal_q <= ~over_touch & (dig_gate_off | ~over_noise);
		end
	end
endmodule : tscfg_chan

// file: dv/tscfg_regs_props.sv
/*
 Checker of the touch sensing configuration bank, seeing only its ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
`include "tscfg_params.svh"
module tscfg_regs_props #(
	parameter int NCH         = 6,
	parameter int LOW_TMO_CYC = `TSCFG_LOW_TMO_CYC
) (
	input wire logic                     CLOCK,
	input wire logic                     ARST_N,
	input wire logic                     HSEL,
	input wire logic [31:0]              HADDR,
	input wire tscfg_pkg::tscfg_htrans_t HTRANS,
	input wire logic                     HWRITE,
	input wire logic                     HREADY,
	input wire logic [31:0]              HRDATA,
	input wire logic                     SCL_PIN,
	input wire logic                     SDA_PIN,
	input wire logic                     CYCLE_STROBE,
	input wire logic [15:0]              BASE_COUNT,
	input wire logic [15:0]              BASE_COUNT_VIEW,
	input wire logic [NCH*8-1:0]         DELTA_OUT,
	input wire logic                     PRESS_EVENT,
	input wire logic                     RELEASE_EVENT,
	input wire logic                     REPEAT_EVENT,
	input wire logic                     BASELINE_RANGE_FAULT_FLAG,
	input wire logic                     CALIB_FAILURE_FLAG,
	input wire logic                     IRQ_REQ,
	input wire logic                     BUS_RESET
);
	import tscfg_pkg::*;
	localparam int IDLE_CYC = `TSCFG_IDLE_TMO_CYC;
	logic [31:0] lo_q;  // Cycles with clock pin low
	logic [31:0] hi_q;  // Cycles with both pins high
	logic [4:0]  ev_q;  // Recent interrupt causes
	logic [3:0]  st_q;  // Recent cycle strobes
	logic        rd_q;  // Read address phase last edge
	// History; counts lead the design's synchronisers, so bounds are safe
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			lo_q <= '0;
			hi_q <= '0;
			ev_q <= '0;
			st_q <= '0;
			rd_q <= 1'b0;
		end
		else
		begin
			lo_q <= SCL_PIN ? 32'h0 : lo_q + 32'h1;
			hi_q <= (SCL_PIN && SDA_PIN) ? hi_q + 32'h1 : 32'h0;
			ev_q <= {ev_q[3:0], PRESS_EVENT | RELEASE_EVENT | REPEAT_EVENT
				| BASELINE_RANGE_FAULT_FLAG | CALIB_FAILURE_FLAG};
			st_q <= {st_q[2:0], CYCLE_STROBE};
			rd_q <= HSEL && HREADY && HTRANS == TSCFG_HTR_NONSEQ && !HWRITE;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// Read address phase, and one outside the three registers
	sequence s_rd;
		HSEL && HREADY && HTRANS == TSCFG_HTR_NONSEQ && !HWRITE;
	endsequence
	sequence s_unm;
		s_rd ##0 !(HADDR inside {32'h7C, 32'h80, 32'h110});
	endsequence
	a_rd_upper: assert property (s_rd |=> HRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	a_unm_zero: assert property (s_unm |=> HRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!$stable(HRDATA) |-> rd_q)
		else $error("read data moved without a read");
	a_tmo_cause: assert property (BUS_RESET |-> lo_q >= LOW_TMO_CYC || hi_q >= IDLE_CYC)
		else $error("bus reset too early");
	a_rst_pulse: assert property (BUS_RESET |=> !BUS_RESET [*8])
		else $error("bus reset repeated");
	a_irq_cause: assert property (IRQ_REQ |-> ev_q != 5'h0)
		else $error("interrupt without cause");
	a_view_scale: assert property ($stable(BASE_COUNT) [*3] |-> BASE_COUNT_VIEW <= BASE_COUNT)
		else $error("base view above base count");
	a_delta_cycle: assert property (!$stable(DELTA_OUT) |-> st_q != 4'h0)
		else $error("delta moved off a sensing cycle");
endmodule : tscfg_regs_props
bind tscfg_regs tscfg_regs_props #(.NCH(NCH), .LOW_TMO_CYC(LOW_TMO_CYC)) u_props (
	.CLOCK(CLOCK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .SCL_PIN(SCL_PIN),
	.SDA_PIN(SDA_PIN), .CYCLE_STROBE(CYCLE_STROBE), .BASE_COUNT(BASE_COUNT),
	.BASE_COUNT_VIEW(BASE_COUNT_VIEW), .DELTA_OUT(DELTA_OUT), .PRESS_EVENT(PRESS_EVENT),
	.RELEASE_EVENT(RELEASE_EVENT), .REPEAT_EVENT(REPEAT_EVENT),
	.BASELINE_RANGE_FAULT_FLAG(BASELINE_RANGE_FAULT_FLAG),
	.CALIB_FAILURE_FLAG(CALIB_FAILURE_FLAG), .IRQ_REQ(IRQ_REQ), .BUS_RESET(BUS_RESET)
);

// file: dv/tscfg_host.sv
/*
 Two-wire management host at the serial pins, idle between frames.
 Assumes the bench changes hold_low just after a clock edge.
*/
`timescale 1ns/10ps
module tscfg_host (
	input  wire logic hold_low,  // Host stuck with clock low
	output logic      scl,
	output logic      sda
);
	// Pulled-up lines rest high; a stuck host drags only the clock
	assign scl = !hold_low;
	assign sda = 1'b1;
endmodule : tscfg_host

// file: dv/testbench.sv
/*
 Self-checking bench of the touch sensing configuration bank.
 Assumes a zero-wait slave and config applied at sensing cycles.
*/
`timescale 1ns/10ps
`include "tscfg_params.svh"
module testbench;
	import tscfg_pkg::*;
	localparam int NCH = 2;
	localparam int TMO = 50;  // Shortened low timeout
	localparam logic [31:0] A[3] = '{32'h7C, 32'h80, 32'h110};
	localparam logic [7:0] RV[3] = '{`TSCFG_RST_SENS, `TSCFG_RST_CFG1, `TSCFG_RST_CFG2};
	localparam logic [7:0] MK[3] = '{`TSCFG_MASK_SENS, `TSCFG_MASK_CFG1, `TSCFG_MASK_CFG2};
	logic          CLOCK = 0, ARST_N = 0, hs = 0, hw = 0, cs = 0, hl = 0, lc = 0, hx = 0;
	logic [31:0]   ha = 0, hd = 0, rd;
	tscfg_htrans_t ht = TSCFG_HTR_IDLE;
	logic [15:0]   raw = 0, bc = 0;
	logic [1:0]    lf = 0, rf = 0, pf = 2'h3;
	logic [4:0]    ev = 0;  // Repeat, press, release, calib, baseline
	logic [7:0]    tt = 8'h40, nt = 8'h10;
	wire           rdy, scl, sda, irq, brst, lp, lhr, hrsp;
	wire [31:0]    hr;
	wire [15:0]    bv, dout;
	wire [1:0]     ns, rok, rrt;
	int            num_errors = 0, cmp_count = 0;
	always #12.5 CLOCK = ~CLOCK;
	tscfg_host u_host (.hold_low(hl), .scl(scl), .sda(sda));
	tscfg_regs #(.NCH(NCH), .LOW_TMO_CYC(TMO)) dut (
		.CLOCK(CLOCK), .ARST_N(ARST_N), .HSEL(hs), .HADDR(ha), .HTRANS(ht), .HWRITE(hw),
		.HSIZE(3'h2), .HWDATA(hd), .HREADY(rdy), .HRDATA(hr), .HREADYOUT(rdy), .HRESP(hrsp),
		.SCL_PIN(scl), .SDA_PIN(sda), .CYCLE_STROBE(cs), .RAW_DELTA({NCH{raw}}),
		.LF_NOISE(lf), .RF_NOISE(rf), .TOUCH_THR(tt), .NOISE_THR(nt),
		.BASELINE_RANGE_FAULT_FLAG(ev[0]), .CALIB_FAILURE_FLAG(ev[1]),
		.PER_INPUT_BASELINE_FAULT(pf), .PRESS_EVENT(ev[3]), .RELEASE_EVENT(ev[2]),
		.REPEAT_EVENT(ev[4]), .LAST_CONV_DONE(lc), .HOLD_EXPIRED(hx), .BASE_COUNT(bc),
		.DELTA_OUT(dout), .NOISE_STATUS(ns), .RECAL_SAMPLE_OK(rok), .RECAL_RETRY(rrt),
		.LONG_HOLD_RECAL(lhr), .LOW_POWER(lp), .IRQ_REQ(irq), .BASE_COUNT_VIEW(bv),
		.BUS_RESET(brst)
	);
	// Verdict, the only exit
	task report_and_stop;
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Waits for ready at an edge, never unbounded
	task ack;
		int n;
		n = 0;
		do begin @(posedge CLOCK); n++; end while (rdy !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			num_errors++;
			$display("FAIL %0t bus hang", $time);
			report_and_stop;
		end
	endtask : ack
	// One single AHB transfer; read data taken at the data phase edge
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		hs <= 1'b1;
		ht <= TSCFG_HTR_NONSEQ;
		ha <= a;
		hw <= w;
		ack;
		ht <= TSCFG_HTR_IDLE;
		hd <= d;
		ack;
		rd = hr;
		chk(hrsp, 32'h0);
	endtask : xfer
	// Two sensing cycles: one loads the shadow, one updates channels
	task apply;
		repeat (2)
		begin
			@(posedge CLOCK) cs <= 1'b1;
			@(posedge CLOCK) cs <= 1'b0;
			repeat (5) @(posedge CLOCK);
		end
	endtask : apply
	function automatic logic [7:0] sat(input int v);
		return v > 127 ? 8'h7F : v < -128 ? 8'h80 : v[7:0];
	endfunction : sat
	// Noise row: channel 0 delta 20h lies between the two thresholds
	task nz(input logic [7:0] c1, c2, input logic l, r, input logic [7:0] ed, input logic en);
		xfer(1, A[1], {24'h0, c1});
		xfer(1, A[2], {24'h0, c2});
		lf <= {1'b0, l};
		rf <= {1'b0, r};
		apply;
		chk(dout[7:0], ed);
		chk(ns[0], en);
		chk(rrt[0], c2[6]);
		if (!(l | r))
			chk(rok[0], c1[5]);
	endtask : nz
	task it(input logic [4:0] s, input logic e);
		int k;
		logic seen;
		seen = 0;
		@(posedge CLOCK) ev <= s;
		@(posedge CLOCK) ev <= 5'h0;
		for (k = 0; k < 8; k++)
		begin
			@(posedge CLOCK);
			seen |= irq;
		end
		chk(seen, e);
	endtask : it
	task tw(input int n, input logic e);
		int k;
		logic seen;
		seen = 0;
		for (k = 0; k < n; k++)
		begin
			@(posedge CLOCK);
			seen |= brst;
		end
		chk(seen, e);
	endtask : tw
	initial
	begin
		int i, r;
		logic [31:0] v;
		void'($urandom(29666));
		repeat (2) @(posedge CLOCK);
		ARST_N <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			xfer(0, A[i], 0);
			chk(rd, {24'h0, RV[i]});
			v = $urandom;
			xfer(1, A[i], v);
			xfer(0, A[i], 0);
			chk(rd, v & {24'h0, MK[i]});
			xfer(1, A[i], {24'h0, RV[i]});
		end
		// Printed offset used as a byte address is unmapped
		xfer(1, 32'h1F, 32'hFF);
		xfer(0, 32'h1F, 0);
		chk(rd, 32'h0);
		// Aligned address above the register window must not alias
		xfer(0, 32'h47C, 0);
		chk(rd, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			r = i == 0 ? 100 : i == 1 ? -100 : int'($urandom_range(60)) - 30;
			raw <= r[15:0];
			bc <= 16'($urandom);
			xfer(1, A[0], {24'h0, 1'b0, i[2:0], 1'b0, i[2:0]});
			apply;
			chk(dout[7:0], sat(r * (1 << (7 - i))));
			chk(bv, bc >> i);
		end
		xfer(1, A[0], 32'h70);
		apply;
		chk(dout[7:0], sat(r));
		raw <= 16'h0020;
		nz(8'h20, 8'h40, 1, 0, 8'h00, 1);
		nz(8'h20, 8'h48, 1, 0, 8'h00, 0);
		nz(8'h30, 8'h48, 1, 0, 8'h20, 0);
		nz(8'h20, 8'h40, 0, 1, 8'h00, 1);
		nz(8'h20, 8'h44, 0, 1, 8'h20, 1);
		nz(8'h00, 8'h40, 0, 0, 8'h20, 0);
		nz(8'h20, 8'h00, 0, 0, 8'h20, 0);
		xfer(1, A[2], 32'h40);
		apply;
		it(5'h01, 0);
		it(5'h02, 0);
		it(5'h04, 1);
		xfer(1, A[2], 32'h53);
		apply;
		it(5'h01, 1);
		it(5'h02, 1);
		it(5'h04, 0);
		it(5'h08, 1);
		it(5'h10, 1);
		// Low power from last conversion until the cycle boundary
		@(posedge CLOCK) lc <= 1'b1;
		@(posedge CLOCK) lc <= 1'b0;
		@(posedge CLOCK);
		chk(lp, 1);
		apply;
		chk(lp, 0);
		xfer(1, A[2], 32'h73);
		apply;
		@(posedge CLOCK) lc <= 1'b1;
		@(posedge CLOCK) lc <= 1'b0;
		@(posedge CLOCK);
		chk(lp, 0);
		// Long hold recalibrates only once enabled
		hx <= 1'b1;
		@(posedge CLOCK);
		@(posedge CLOCK);
		chk(lhr, 0);
		xfer(1, A[1], 32'h28);
		apply;
		chk(lhr, 1);
		hx <= 1'b0;
		hl <= 1'b1;
		tw(TMO + 100, 0);
		hl <= 1'b0;
		xfer(1, A[1], 32'hA0);
		apply;
		hl <= 1'b1;
		tw(TMO + 20, 1);
		hl <= 1'b0;
		tw(8100, 1);
		report_and_stop;
	end
	// Cuts a hung run short
	initial
	begin
		repeat (100000) @(posedge CLOCK);
		num_errors++;
		$display("FAIL %0t run too long", $time);
		report_and_stop;
	end
endmodule : testbench
